// ===== verification/otp_part_model.sv
// Purpose: Behavioural four-byte OTP part seen by the sequencer.
// Assumes: A byte takes need[] pulses to program; the bench sets need and corrupt_addr.
// Notes:   A released bus shows the inverse of the last value, never a held copy.
`timescale 1ns/100ps
module otp_part_model #(
	parameter logic [7:0] MFR_CODE = 8'h5A, // Arbitrary value.
	parameter logic [7:0] DEV_CODE = 8'hC3  // Arbitrary value.
) (
	// Part pins
	input wire logic [16:0] i_addr,
	input wire logic        i_ce_n,
	input wire logic        i_oe_n,
	input wire logic        i_program_strobe_n,
	input wire logic [7:0]  i_dq,
	input wire logic        i_identification_high_voltage,
	input wire logic        i_vcc_program_level,
	input wire logic        i_vpp_program_level,
	output logic [7:0]      o_dq
);
	logic [7:0] mem [4];
	logic [7:0] value;
	logic [7:0] held;
	logic [1:0] a;
	int         pulses [4];
	int         need [4];
	int         corrupt_addr, low_reads, pulsed, order_err;
	task automatic clear();
		for (int i = 0; i < 4; i++) begin
			mem[i] = 8'hFF;
			pulses[i] = 0;
			need[i] = 1;
		end
		corrupt_addr = -1;
		low_reads = 0;
		pulsed = 0;
		order_err = 0;
	endtask
	initial clear();
	assign a = i_addr[1:0];
	// Programming only counts with both supplies raised and outputs disabled.
	always @(posedge i_program_strobe_n) begin
		if (!i_ce_n && i_oe_n && i_vcc_program_level && i_vpp_program_level) begin
			if (pulses[a] == 0) pulsed++;
			pulses[a]++;
			if (pulses[a] == need[a]) mem[a] = mem[a] & i_dq;
		end
	end
	// A verify read before every byte has had its first pulse is an ordering fault.
	always @(negedge i_oe_n) begin
		if (!i_identification_high_voltage && i_vcc_program_level && pulsed < 4) order_err = 1;
		if (!i_identification_high_voltage && !i_vcc_program_level) low_reads++;
	end
	always @* begin
		if (i_identification_high_voltage) value = a[0] ? DEV_CODE : MFR_CODE;
		else if (!i_vcc_program_level && a == corrupt_addr) value = ~mem[a];
		else value = mem[a];
	end
	always @(value or i_ce_n or i_oe_n) if (!i_ce_n && !i_oe_n) held = value;
	assign o_dq = (!i_ce_n && !i_oe_n) ? value : ~held;
endmodule

// ===== verification/otp_prog_sequencer_props.sv
// Purpose: Assertions on the sequencer's part pins and command outputs.
// Assumes: One clock domain; pulse and read widths are counted in helper registers.
// Notes:   Widths are exact figures taken from the hand-over timing.
`timescale 1ns/100ps
module otp_prog_sequencer_props #(
	parameter logic [13:0] PULSE_CYCLES = 14'h2710,
	parameter logic [16:0] LAST_ADDR    = 17'h1FFFF
) (
	// Clock and reset
	input wire logic        i_clk,
	input wire logic        i_rst_n,
	// Part pins
	input wire logic [16:0] o_addr,
	input wire logic        o_ce_n,
	input wire logic        o_oe_n,
	input wire logic        o_program_strobe_n,
	input wire logic [7:0]  o_dq_out,
	input wire logic        o_dq_oe_n,
	input wire logic        o_identification_high_voltage,
	// Status and supplies
	input wire logic        o_busy,
	input wire logic        o_pass,
	input wire logic        o_fail,
	input wire logic        o_vcc_program_level,
	input wire logic        o_vpp_program_level
);
	localparam int RD_CYC = otp_prog_pkg::READ_WAIT_CYC + 1;
	logic [13:0] pulse_cnt_r;
	logic [7:0]  read_cnt_r;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// ****************************************************************
	// Width counters
	// ****************************************************************
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pulse_cnt_r <= 14'h0000;
			read_cnt_r  <= 8'h00;
		end else begin
			pulse_cnt_r <= o_program_strobe_n ? 14'h0000 : pulse_cnt_r + 14'h0001;
			read_cnt_r  <= o_oe_n ? 8'h00 : read_cnt_r + 8'h01;
		end
	end
	property p_pulse_width;
		$rose(o_program_strobe_n) |-> pulse_cnt_r == PULSE_CYCLES;
	endproperty
	a_pulse_width: assert property (p_pulse_width) else $error("pulse width wrong");
	property p_pulse_ctrl;
		!o_program_strobe_n |-> !o_ce_n && o_oe_n && !o_dq_oe_n && o_vcc_program_level
			&& o_vpp_program_level && !o_identification_high_voltage;
	endproperty
	a_pulse_ctrl: assert property (p_pulse_ctrl) else $error("pulse conditions wrong");
	property p_pulse_stable;
		!o_program_strobe_n |-> $stable(o_addr) && $stable(o_dq_out);
	endproperty
	a_pulse_stable: assert property (p_pulse_stable) else $error("pulse data moved");
	property p_supply_order;
		o_vpp_program_level |-> o_vcc_program_level && $past(o_vcc_program_level);
	endproperty
	a_supply_order: assert property (p_supply_order) else $error("supply order wrong");
	property p_first_addr;
		$rose(o_vpp_program_level) |-> o_addr == 17'h00000;
	endproperty
	a_first_addr: assert property (p_first_addr) else $error("start address wrong");
	property p_read_ctrl;
		!o_oe_n |-> !o_ce_n && o_program_strobe_n && o_dq_oe_n;
	endproperty
	a_read_ctrl: assert property (p_read_ctrl) else $error("read conditions wrong");
	property p_read_width;
		$rose(o_oe_n) |-> read_cnt_r == RD_CYC;
	endproperty
	a_read_width: assert property (p_read_width) else $error("read width wrong");
	property p_float;
		$rose(o_oe_n) |-> (o_oe_n && o_dq_oe_n && o_program_strobe_n) [*8];
	endproperty
	a_float: assert property (p_float) else $error("bus driven during float");
	property p_id_supply;
		o_identification_high_voltage |-> !o_vpp_program_level && !o_vcc_program_level
			&& o_program_strobe_n;
	endproperty
	a_id_supply: assert property (p_id_supply) else $error("identify supplies wrong");
	property p_addr_range;
		(!o_oe_n || !o_program_strobe_n) |-> o_addr <= LAST_ADDR;
	endproperty
	a_addr_range: assert property (p_addr_range) else $error("address out of range");
	c_fail: cover property ($rose(o_fail));
	c_pass: cover property ($rose(o_pass));
	c_ident: cover property ($rose(o_identification_high_voltage));
	c_busy: cover property ($rose(o_busy));
endmodule
bind otp_prog_sequencer otp_prog_sequencer_props #(
	.PULSE_CYCLES(PULSE_CYCLES), .LAST_ADDR(LAST_ADDR)) props_i (
	.i_clk(i_clk), .i_rst_n(i_rst_n), .o_addr(o_addr), .o_ce_n(o_ce_n), .o_oe_n(o_oe_n),
	.o_program_strobe_n(o_program_strobe_n), .o_dq_out(o_dq_out), .o_dq_oe_n(o_dq_oe_n),
	.o_identification_high_voltage(o_identification_high_voltage), .o_busy(o_busy),
	.o_pass(o_pass), .o_fail(o_fail), .o_vcc_program_level(o_vcc_program_level),
	.o_vpp_program_level(o_vpp_program_level));

// ===== verification/tb_otp_eprom_program_sequencer.sv
// Purpose: Self-checking bench for the OTP programming sequencer with a part model.
// Assumes: Four-byte array and 20-cycle pulses keep the run short.
// Notes:   The driver queues expected results; a monitor pops one after each done.
`timescale 1ns/100ps
module tb_otp_eprom_program_sequencer;
	typedef struct packed {
		logic        prog;
		logic        pass;
		logic        fail;
		logic [16:0] faddr;
		logic [7:0]  mfr;
		logic [7:0]  dev;
	} note_type;
	localparam logic [7:0] MFR = 8'h5A; // Arbitrary value.
	localparam logic [7:0] DEV = 8'hC3; // Arbitrary value.
	logic        i_clk = 1'b0;
	logic        i_rst_n = 1'b0;
	logic        i_start_program = 1'b0;
	logic        i_start_identify = 1'b0;
	logic        o_busy, o_done, o_pass, o_fail, o_ce_n, o_oe_n, o_strobe_n, o_dq_oe_n;
	logic        o_id_hv, o_vcc, o_vpp, done_d;
	logic [16:0] o_fail_addr, o_src_addr, o_addr;
	logic [7:0]  o_mfr_code, o_dev_code, i_src_data, o_dq_out, i_dq_in, part_dq;
	logic [7:0]  src [4];
	note_type    notes [$];
	note_type    n;
	int          seed = 32'hDB0A;
	int          miscompares = 0;
	int          check_count = 0;
	always #5 i_clk = ~i_clk;
	assign i_src_data = src[o_src_addr[1:0]];
	assign i_dq_in = (o_dq_oe_n === 1'b0) ? o_dq_out : part_dq;
	otp_prog_sequencer #(.PULSE_CYCLES(14'h0014), .LAST_ADDR(17'h00003)) otp_prog_sequencer_i (
		.i_clk(i_clk), .i_rst_n(i_rst_n), .i_start_program(i_start_program),
		.i_start_identify(i_start_identify), .o_busy(o_busy), .o_done(o_done),
		.o_pass(o_pass), .o_fail(o_fail), .o_fail_addr(o_fail_addr), .o_mfr_code(o_mfr_code),
		.o_dev_code(o_dev_code), .o_src_addr(o_src_addr), .i_src_data(i_src_data),
		.o_addr(o_addr), .o_ce_n(o_ce_n), .o_oe_n(o_oe_n), .o_program_strobe_n(o_strobe_n),
		.o_dq_out(o_dq_out), .o_dq_oe_n(o_dq_oe_n), .i_dq_in(i_dq_in),
		.o_identification_high_voltage(o_id_hv), .o_vcc_program_level(o_vcc),
		.o_vpp_program_level(o_vpp));
	otp_part_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) otp_part_model_i (
		.i_addr(o_addr), .i_ce_n(o_ce_n), .i_oe_n(o_oe_n), .i_program_strobe_n(o_strobe_n),
		.i_dq(i_dq_in), .i_identification_high_voltage(o_id_hv), .i_vcc_program_level(o_vcc),
		.i_vpp_program_level(o_vpp), .o_dq(part_dq));
	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s: expected %0h, seen %0h", what, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("checks %0d, mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// A start given while busy must be ignored, so no extra result is queued for it.
	task automatic run(input note_type e, input logic poke, input string name);
		int k;
		notes.push_back(e);
		@(posedge i_clk);
		#1 i_start_program = e.prog;
		i_start_identify = !e.prog;
		@(posedge i_clk);
		#1 i_start_program = 1'b0;
		i_start_identify = 1'b0;
		if (poke) begin
			repeat (3) @(posedge i_clk);
			#1 i_start_identify = 1'b1;
			@(posedge i_clk);
			#1 i_start_identify = 1'b0;
		end
		k = 0;
		while (o_busy !== 1'b0 && k < 30000) begin
			@(posedge i_clk);
			#1 k++;
		end
		if (k >= 30000) begin
			miscompares++;
			conclude();
		end else begin
			repeat (2) @(posedge i_clk);
			$display("test %s ended", name);
		end
	endtask
	// Results are compared one cycle after done, when every status level has settled.
	always @(negedge i_clk) begin
		if (done_d) begin
			if (notes.size() == 0) check("spare done", 17'h00001, 17'h00000);
			else begin
				n = notes.pop_front();
				if (n.prog) begin
					check("pass", 17'(o_pass), 17'(n.pass));
					check("fail", 17'(o_fail), 17'(n.fail));
					if (n.fail) check("fail addr", o_fail_addr, n.faddr);
				end else begin
					check("maker code", 17'(o_mfr_code), 17'(n.mfr));
					check("type code", 17'(o_dev_code), 17'(n.dev));
				end
			end
		end
		done_d = (o_done === 1'b1);
	end
	initial begin
		repeat (90000) @(posedge i_clk);
		miscompares++;
		conclude();
	end
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	initial begin
		// Bit zero is cleared so no byte equals the erased value and every retry is exercised.
		for (int i = 0; i < 4; i++) src[i] = 8'($random(seed)) & 8'hFE;
		repeat (6) @(posedge i_clk);
		#1 i_rst_n = 1'b1;
		run('{1'b1, 1'b1, 1'b0, 17'h00000, 8'h00, 8'h00}, 1'b1, "clean program");
		for (int i = 0; i < 4; i++) begin
			check("byte", 17'(otp_part_model_i.mem[i]), 17'(src[i]));
			check("pulses", 17'(otp_part_model_i.pulses[i]), 17'h00001);
		end
		check("final reads", 17'(otp_part_model_i.low_reads), 17'h00004);
		check("verify order", 17'(otp_part_model_i.order_err), 17'h00000);
		otp_part_model_i.clear();
		otp_part_model_i.need[2] = 4;
		run('{1'b1, 1'b1, 1'b0, 17'h00000, 8'h00, 8'h00}, 1'b0, "retry program");
		check("retry pulses", 17'(otp_part_model_i.pulses[2]), 17'h00004);
		otp_part_model_i.clear();
		otp_part_model_i.need[1] = 12;
		run('{1'b1, 1'b0, 1'b1, 17'h00001, 8'h00, 8'h00}, 1'b0, "retry exhausted");
		check("limit pulses", 17'(otp_part_model_i.pulses[1]), 17'h0000B);
		otp_part_model_i.clear();
		otp_part_model_i.corrupt_addr = 3;
		run('{1'b1, 1'b0, 1'b1, 17'h00003, 8'h00, 8'h00}, 1'b0, "final mismatch");
		check("final reads", 17'(otp_part_model_i.low_reads), 17'h00004);
		run('{1'b0, 1'b0, 1'b0, 17'h00000, MFR, DEV}, 1'b0, "identify");
		repeat (5) @(posedge i_clk);
		check("pending results", 17'(notes.size()), 17'h00000);
		conclude();
	end
endmodule

// ===== verilog/otp_prog_pkg.sv
// Purpose: Shared constants for the one-time-programmable memory programming sequencer.
// Assumes: 100 MHz system clock; byte-wide array with a 17-bit address.
// Notes:   Times are kept in their printed units; cycle counts derive from them.
package otp_prog_pkg;

	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned ADDR_W        = 17;
	localparam int unsigned DATA_W        = 8;
	localparam int unsigned TIMER_W       = 14;
	localparam int unsigned SYNC_STAGES   = 2;

	// *****************************************************************
	// Timing
	// *****************************************************************
	localparam int unsigned PULSE_TIME_US      = 100;
	localparam int unsigned PULSE_MIN_US       = 95;
	localparam int unsigned PULSE_MAX_US       = 105;
	localparam int unsigned SETUP_TIME_US      = 2;
	localparam int unsigned DATA_VALID_DELAY_NS   = 150;
	localparam int unsigned OUTPUT_FLOAT_DELAY_NS = 130;

	localparam int unsigned PULSE_CYC     = (PULSE_TIME_US * 1000) / CLK_PERIOD_NS;
	localparam int unsigned PULSE_MIN_CYC = (PULSE_MIN_US * 1000 + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int unsigned PULSE_MAX_CYC = (PULSE_MAX_US * 1000) / CLK_PERIOD_NS;
	localparam int unsigned SETUP_CYC     = (SETUP_TIME_US * 1000 + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	// Sampling waits the data valid delay plus the input synchroniser depth and one more cycle.
	localparam int unsigned READ_WAIT_CYC = (DATA_VALID_DELAY_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS + SYNC_STAGES + 1;
	localparam int unsigned FLOAT_CYC     = (OUTPUT_FLOAT_DELAY_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;

	// *****************************************************************
	// Algorithm
	// *****************************************************************
	localparam logic [3:0]        MAX_RETRY      = 4'hA;
	localparam logic [ADDR_W-1:0] ADDR_FIRST     = 17'h00000;
	localparam logic [ADDR_W-1:0] ADDR_LAST_FULL = 17'h1FFFF;

	typedef enum logic [1:0] {
		PH_FIRST,
		PH_LOOP,
		PH_FINAL,
		PH_ID
	} phase_type;

endpackage

// ===== verilog/otp_prog_sequencer.sv
// Purpose: Programmer-side sequencer that programs, verifies and identifies an OTP memory.
// Assumes: Source data answers o_src_addr within one cycle; supply outputs steer regulators.
// Notes:   Outputs to the part are all registered; the data bus input is synchronised.
// What this block does
// - Program pulses last 100 us, inside the 95 to 105 us window.
// - Programming starts with the first array address selected.
// - Core supply goes to 6.5 V and programming supply to 13.0 V.
// - Core supply rises first and falls last around the programming supply.
// - First pass gives each address one pulse without any verify read.
// - A separate verify and reprogram loop then visits each address until the last passes or a byte fails.
// - A failing byte gets single pulses, at most ten, each followed by verify.
// - A byte still failing after ten extra pulses fails the whole device.
// - A verified byte advances the address until all addresses are checked.
// - After the loop both supplies drop to 5.0 V before the final check.
// - Final pass rereads every byte; device passes only if all match.
// - Sample after the data valid delay; allow the float delay after release.
// - Identification mode is entered by high voltage on the select pin.
`timescale 1ns/100ps
module otp_prog_sequencer #(
	parameter logic [otp_prog_pkg::TIMER_W-1:0] PULSE_CYCLES = 14'(otp_prog_pkg::PULSE_CYC),
	parameter logic [otp_prog_pkg::ADDR_W-1:0]  LAST_ADDR    = otp_prog_pkg::ADDR_LAST_FULL
) (
	// Clock and reset
	input  wire logic                              i_clk,
	input  wire logic                              i_rst_n,
	// User commands and results
	input  wire logic                              i_start_program,
	input  wire logic                              i_start_identify,
	output logic                                   o_busy,
	output logic                                   o_done,
	output logic                                   o_pass,
	output logic                                   o_fail,
	output logic [otp_prog_pkg::ADDR_W-1:0]        o_fail_addr,
	output logic [otp_prog_pkg::DATA_W-1:0]        o_mfr_code,
	output logic [otp_prog_pkg::DATA_W-1:0]        o_dev_code,
	// Source image
	output logic [otp_prog_pkg::ADDR_W-1:0]        o_src_addr,
	input  wire logic [otp_prog_pkg::DATA_W-1:0]   i_src_data,
	// Memory part pins
	output logic [otp_prog_pkg::ADDR_W-1:0]        o_addr,
	output logic                                   o_ce_n,
	output logic                                   o_oe_n,
	output logic                                   o_program_strobe_n,
	output logic [otp_prog_pkg::DATA_W-1:0]        o_dq_out,
	output logic                                   o_dq_oe_n,
	input  wire logic [otp_prog_pkg::DATA_W-1:0]   i_dq_in,
	output logic                                   o_identification_high_voltage,
	// Supply steering
	output logic                                   o_vcc_program_level,
	output logic                                   o_vpp_program_level
);

	typedef enum logic [3:0] {
		S_IDLE,
		S_VCC_UP,
		S_VPP_UP,
		S_PSETUP,
		S_PULSE,
		S_PHOLD,
		S_RSETUP,
		S_RCHECK,
		S_RFLOAT,
		S_VPP_DN,
		S_VCC_DN,
		S_ID_UP,
		S_ID_DN,
		S_DONE
	} state_type;

	state_type                          state_r;
	state_type                          state_nxt;
	otp_prog_pkg::phase_type            phase_r;
	logic [otp_prog_pkg::ADDR_W-1:0]    addr_r;
	logic [3:0]                         retry_r;
	logic                               match_r;
	logic                               fail_r;
	logic                               tmr_load;
	logic [otp_prog_pkg::TIMER_W-1:0]   tmr_count;
	logic                               tmr_done;
	logic                               last;
	logic [otp_prog_pkg::DATA_W-1:0]    dq_meta_r;
	logic [otp_prog_pkg::DATA_W-1:0]    dq_sync_r;

	assign last       = (addr_r == LAST_ADDR);
	assign o_addr     = addr_r;
	assign o_src_addr = addr_r;
	assign o_fail     = fail_r;

	otp_prog_timer u_timer (
		.i_clk     (i_clk),
		.i_rst_n   (i_rst_n),
		.i_load    (tmr_load),
		.i_count   (tmr_count),
		.o_expired (tmr_done)
	);

	// *****************************************************************
	// Read data synchroniser
	// *****************************************************************
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			dq_meta_r <= '0;
			dq_sync_r <= '0;
		end else begin
			dq_meta_r <= i_dq_in;
			dq_sync_r <= dq_meta_r;
		end
	end

	// *****************************************************************
	// Sequence
	// *****************************************************************
	always_comb begin
		state_nxt = state_r;
		tmr_load  = 1'b0;
		tmr_count = 14'(otp_prog_pkg::SETUP_CYC);
		unique case (state_r)
			S_IDLE: begin
				if (i_start_program || i_start_identify) begin
					state_nxt = i_start_program ? S_VCC_UP : S_ID_UP;
					tmr_load  = 1'b1;
				end
			end
			S_VCC_UP, S_VPP_UP: begin
				if (tmr_done) begin
					state_nxt = (state_r == S_VCC_UP) ? S_VPP_UP : S_PSETUP;
					tmr_load  = 1'b1;
				end
			end
			S_PSETUP: begin
				if (tmr_done) begin
					state_nxt = S_PULSE;
					tmr_load  = 1'b1;
					tmr_count = PULSE_CYCLES;
				end
			end
			S_PULSE: begin
				if (tmr_done) begin
					state_nxt = S_PHOLD;
					tmr_load  = 1'b1;
				end
			end
			S_PHOLD: begin
				if (tmr_done) begin
					tmr_load = 1'b1;
					if (phase_r == otp_prog_pkg::PH_FIRST && !last) begin
						state_nxt = S_PSETUP;
					end else begin
						state_nxt = S_RSETUP;
						tmr_count = 14'(otp_prog_pkg::READ_WAIT_CYC);
					end
				end
			end
			S_RSETUP: begin
				if (tmr_done) begin
					state_nxt = S_RCHECK;
				end
			end
			S_RCHECK: begin
				state_nxt = S_RFLOAT;
				tmr_load  = 1'b1;
				tmr_count = 14'(otp_prog_pkg::FLOAT_CYC);
			end
			S_RFLOAT: begin
				if (tmr_done) begin
					tmr_load  = 1'b1;
					tmr_count = 14'(otp_prog_pkg::READ_WAIT_CYC);
					state_nxt = S_RSETUP;
					if (phase_r == otp_prog_pkg::PH_LOOP) begin
						if (match_r && last) begin
							state_nxt = S_VPP_DN;
							tmr_count = 14'(otp_prog_pkg::SETUP_CYC);
						end else if (!match_r && retry_r == otp_prog_pkg::MAX_RETRY) begin
							state_nxt = S_VPP_DN;
							tmr_count = 14'(otp_prog_pkg::SETUP_CYC);
						end else if (!match_r) begin
							state_nxt = S_PSETUP;
							tmr_count = 14'(otp_prog_pkg::SETUP_CYC);
						end
					end else if (phase_r == otp_prog_pkg::PH_FINAL && last) begin
						state_nxt = S_DONE;
					end else if (phase_r == otp_prog_pkg::PH_ID && addr_r[0]) begin
						state_nxt = S_ID_DN;
						tmr_count = 14'(otp_prog_pkg::SETUP_CYC);
					end
				end
			end
			S_VPP_DN: begin
				if (tmr_done) begin
					state_nxt = S_VCC_DN;
					tmr_load  = 1'b1;
				end
			end
			S_VCC_DN: begin
				if (tmr_done) begin
					state_nxt = fail_r ? S_DONE : S_RSETUP;
					tmr_load  = !fail_r;
					tmr_count = 14'(otp_prog_pkg::READ_WAIT_CYC);
				end
			end
			S_ID_UP: begin
				if (tmr_done) begin
					state_nxt = S_RSETUP;
					tmr_load  = 1'b1;
					tmr_count = 14'(otp_prog_pkg::READ_WAIT_CYC);
				end
			end
			S_ID_DN: begin
				if (tmr_done) begin
					state_nxt = S_DONE;
				end
			end
			S_DONE: begin
				state_nxt = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_r <= S_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// *****************************************************************
	// Address, phase and retry tracking
	// *****************************************************************
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			phase_r <= otp_prog_pkg::PH_FIRST;
			addr_r  <= otp_prog_pkg::ADDR_FIRST;
			retry_r <= 4'h0;
		end else if (state_r == S_IDLE && (i_start_program || i_start_identify)) begin
			phase_r <= i_start_program ? otp_prog_pkg::PH_FIRST : otp_prog_pkg::PH_ID;
			addr_r  <= otp_prog_pkg::ADDR_FIRST;
			retry_r <= 4'h0;
		end else if (state_r == S_PHOLD && tmr_done) begin
			if (phase_r == otp_prog_pkg::PH_FIRST && last) begin
				phase_r <= otp_prog_pkg::PH_LOOP;
				addr_r  <= otp_prog_pkg::ADDR_FIRST;
			end else if (phase_r == otp_prog_pkg::PH_FIRST) begin
				addr_r <= addr_r + 17'h00001;
			end else begin
				retry_r <= retry_r + 4'h1;
			end
		end else if (state_r == S_RFLOAT && tmr_done && state_nxt == S_RSETUP) begin
			// Address moves only with output enable high, so each read sees one address.
			addr_r  <= addr_r + 17'h00001;
			retry_r <= 4'h0;
		end else if (state_r == S_VCC_DN && tmr_done) begin
			phase_r <= otp_prog_pkg::PH_FINAL;
			addr_r  <= otp_prog_pkg::ADDR_FIRST;
		end
	end

	// *****************************************************************
	// Verify results
	// *****************************************************************
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			match_r     <= 1'b0;
			fail_r      <= 1'b0;
			o_fail_addr <= '0;
			o_mfr_code  <= '0;
			o_dev_code  <= '0;
			o_pass      <= 1'b0;
			o_done      <= 1'b0;
			o_busy      <= 1'b0;
		end else begin
			o_busy <= (state_nxt != S_IDLE);
			o_done <= (state_nxt == S_DONE);
			if (state_r == S_IDLE && i_start_program) begin
				fail_r <= 1'b0;
				o_pass <= 1'b0;
			end
			if (state_r == S_RCHECK) begin
				match_r <= (dq_sync_r == i_src_data);
				if (phase_r == otp_prog_pkg::PH_ID && !addr_r[0]) begin
					o_mfr_code <= dq_sync_r;
				end
				if (phase_r == otp_prog_pkg::PH_ID && addr_r[0]) begin
					o_dev_code <= dq_sync_r;
				end
				if (phase_r == otp_prog_pkg::PH_FINAL && dq_sync_r != i_src_data && !fail_r) begin
					fail_r      <= 1'b1;
					o_fail_addr <= addr_r;
				end
			end
			if (state_r == S_RFLOAT && tmr_done && phase_r == otp_prog_pkg::PH_LOOP
				&& !match_r && retry_r == otp_prog_pkg::MAX_RETRY) begin
				fail_r      <= 1'b1;
				o_fail_addr <= addr_r;
			end
			if (state_r == S_RFLOAT && tmr_done && phase_r == otp_prog_pkg::PH_FINAL && last
				&& !fail_r && match_r) begin
				o_pass <= 1'b1;
			end
		end
	end

	// *****************************************************************
	// Supplies and identification voltage
	// *****************************************************************
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_vcc_program_level           <= 1'b0;
			o_vpp_program_level           <= 1'b0;
			o_identification_high_voltage <= 1'b0;
		end else begin
			if (state_nxt == S_VCC_UP) begin
				o_vcc_program_level <= 1'b1;
			end else if (state_nxt == S_VCC_DN) begin
				o_vcc_program_level <= 1'b0;
			end
			if (state_nxt == S_VPP_UP) begin
				o_vpp_program_level <= 1'b1;
			end else if (state_nxt == S_VPP_DN) begin
				o_vpp_program_level <= 1'b0;
			end
			if (state_nxt == S_ID_UP) begin
				o_identification_high_voltage <= 1'b1;
			end else if (state_nxt == S_ID_DN || state_nxt == S_IDLE) begin
				o_identification_high_voltage <= 1'b0;
			end
		end
	end

	// *****************************************************************
	// Control strobes and write data
	// *****************************************************************
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_ce_n             <= 1'b1;
			o_oe_n             <= 1'b1;
			o_program_strobe_n <= 1'b1;
			o_dq_oe_n          <= 1'b1;
			o_dq_out           <= '0;
		end else begin
			o_ce_n             <= (state_nxt == S_IDLE || state_nxt == S_DONE);
			o_oe_n             <= !(state_nxt == S_RSETUP || state_nxt == S_RCHECK);
			o_program_strobe_n <= (state_nxt != S_PULSE);
			o_dq_oe_n          <= !(state_nxt == S_PSETUP || state_nxt == S_PULSE
				|| state_nxt == S_PHOLD);
			// Data follows the source only during setup, then is frozen for the pulse.
			if (state_nxt == S_PSETUP) begin
				o_dq_out <= i_src_data;
			end
		end
	end

endmodule

// ===== verilog/otp_prog_timer.sv
// Purpose: Down-counting interval timer for the programming sequencer.
// Assumes: Loaded on the edge that enters a timed state.
// Notes:   o_expired is high in the last cycle of a loaded interval of i_count cycles.
`timescale 1ns/100ps
module otp_prog_timer (
	// Clock and reset
	input  wire logic                               i_clk,
	input  wire logic                               i_rst_n,
	// Control
	input  wire logic                               i_load,
	input  wire logic [otp_prog_pkg::TIMER_W-1:0]   i_count,
	output logic                                    o_expired
);

	logic [otp_prog_pkg::TIMER_W-1:0] cnt_r;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_r <= '0;
		end else if (i_load) begin
			cnt_r <= i_count - 14'h0001;
		end else if (cnt_r != '0) begin
			cnt_r <= cnt_r - 14'h0001;
		end
	end

	assign o_expired = (cnt_r == '0);

endmodule
